/* File: bench/pwr_seq_checker.sv */
// Port-level assertions for the power sequencer.
`timescale 1ns/1ps
module pwr_seq_checker #(
  parameter logic [27:0] SHORT_CYC = 28'h14,
  parameter logic [27:0] LONG_CYC  = 28'h28
) (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       rtc_wake_i,
  input wire logic       usb_wake_i,
  input wire logic       sw_sleep_req_i,
  input wire logic [2:0] sw_sleep_state_i,
  input wire logic       sw_off_req_i,
  input wire logic [1:0] gstate_o,
  input wire logic [2:0] sleep_state_o,
  input wire logic       main_power_o,
  input wire logic       cpu_stop_o,
  input wire logic       wake_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_power_follows: assert property
    (main_power_o == (gstate_o == 2'h1 || sleep_state_o == 3'h1)) else $error("main power bad");
  a_cpu_stopped: assert property
    (cpu_stop_o == (gstate_o == 2'h2 && sleep_state_o == 3'h1)) else $error("cpu stop bad");
  a_on_no_sleep: assert property
    ((gstate_o == 2'h1) == (sleep_state_o == 3'h0)) else $error("sleep code bad");
  a_sw_off_taken: assert property
    (gstate_o == 2'h1 && sw_off_req_i |=> gstate_o == 2'h0 && sleep_state_o == 3'h5)
    else $error("soft-off not taken");
  a_sw_sleep_taken: assert property
    (gstate_o == 2'h1 && sw_sleep_req_i && !sw_off_req_i && sw_sleep_state_i == 3'h3
     |=> gstate_o == 2'h2 && sleep_state_o == 3'h3) else $error("sleep not taken");
  a_wake_pulse: assert property
    (wake_event_o |-> gstate_o == 2'h1 ##1 !wake_event_o) else $error("wake pulse bad");
  a_rtc_wakes: assert property
    (gstate_o != 2'h1 && $rose(rtc_wake_i) |-> ##[1:8] gstate_o == 2'h1)
    else $error("rtc wake lost");
  a_rtc_flags: assert property
    (gstate_o != 2'h1 && $rose(rtc_wake_i) |-> ##[1:8] wake_event_o)
    else $error("wake event missing");
  a_usb_refused: assert property
    (gstate_o == 2'h2 && sleep_state_o == 3'h4 && $rose(usb_wake_i) |-> (gstate_o == 2'h2) [*8])
    else $error("usb woke from disk sleep");
endmodule : pwr_seq_checker
bind pwr_seq pwr_seq_checker #(
  .SHORT_CYC (SHORT_CYC),
  .LONG_CYC  (LONG_CYC)
) chk_u (
  .clk_i            (clk_i),
  .reset_n_i        (reset_n_i),
  .rtc_wake_i       (rtc_wake_i),
  .usb_wake_i       (usb_wake_i),
  .sw_sleep_req_i   (sw_sleep_req_i),
  .sw_sleep_state_i (sw_sleep_state_i),
  .sw_off_req_i     (sw_off_req_i),
  .gstate_o         (gstate_o),
  .sleep_state_o    (sleep_state_o),
  .main_power_o     (main_power_o),
  .cpu_stop_o       (cpu_stop_o),
  .wake_event_o     (wake_event_o)
);

/* File: bench/pwr_seq_tb_top.sv */
// Self-checking bench for the power sequencer.
`timescale 1ns/1ps
module pwr_seq_tb_top;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       pme_enable_i = 1'b1;
  logic       sw_sleep_req_i = 1'b0;
  logic [2:0] sw_sleep_state_i = 3'h0;
  logic       sw_off_req_i = 1'b0;
  logic       last_on_i = 1'b0;
  logic [6:0] act;
  logic [1:0] gstate_o;
  logic [2:0] sleep_state_o;
  int         n_fail = 0;
  int         n_tests = 0;
  initial forever #20 clk_i = ~clk_i;
  wake_src_model src_u (.clk_i(clk_i), .act_o(act));
  pwr_seq #(.SHORT_CYC(28'h14), .LONG_CYC(28'h28)) dut_u (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .switch_i(act[0]), .rtc_wake_i(act[1]), .lan_wake_i(act[2]),
    .usb_wake_i(act[3]), .cir_wake_i(act[4]), .pme_n_i(~act[5]), .wake_n_i(~act[6]),
    .pme_enable_i(pme_enable_i), .sw_sleep_req_i(sw_sleep_req_i),
    .sw_sleep_state_i(sw_sleep_state_i), .sw_off_req_i(sw_off_req_i), .last_on_i(last_on_i),
    .gstate_o(gstate_o), .sleep_state_o(sleep_state_o), .main_power_o(), .cpu_stop_o(),
    .wake_event_o());
  task automatic check(input logic [4:0] exp);
    n_tests++;
    if ({gstate_o, sleep_state_o} !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {gstate_o, sleep_state_o}, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic do_reset(input logic on);
    last_on_i <= on;
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  task automatic sleep_to(input logic [2:0] s);
    sw_sleep_state_i <= s;
    sw_off_req_i <= (s == 3'h5);
    sw_sleep_req_i <= (s != 3'h5);
    @(posedge clk_i);
    sw_off_req_i <= 1'b0;
    sw_sleep_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(s == 3'h5 ? 5'h05 : {2'h2, s});
  endtask : sleep_to
  task automatic t_press;
    do_reset(1'b0);
    check(5'h05);
    src_u.hold(0, 10);
    check(5'h08);
    src_u.hold(0, 10);
    check(5'h13);
    src_u.hold(0, 10);
    check(5'h08);
    src_u.hold(0, 30);
    check(5'h08);
    src_u.hold(0, 50);
    check(5'h05);
  endtask : t_press
  task automatic t_wakes;
    logic [2:0] st[4] = '{3'h1, 3'h3, 3'h4, 3'h5};
    logic       ok;
    do_reset(1'b1);
    check(5'h08);
    foreach (st[i])
      for (int k = 0; k < 7; k++)
      begin
        sleep_to(st[i]);
        ok = (k == 3) ? st[i] < 3'h4 : (k == 4) ? st[i] != 3'h1 : 1'b1;
        src_u.hold(k, 6);
        if (!ok)
        begin
          check(st[i] == 3'h5 ? 5'h05 : {2'h2, st[i]});
          src_u.hold(0, 10);
        end
        check(5'h08);
      end
  endtask : t_wakes
  task automatic t_pme_gate;
    pme_enable_i <= 1'b0;
    sleep_to(3'h3);
    src_u.hold(5, 6);
    check(5'h13);
    pme_enable_i <= 1'b1;
    src_u.hold(5, 6);
    check(5'h08);
  endtask : t_pme_gate
  task automatic t_bad_req;
    sw_sleep_state_i <= 3'h2;
    sw_sleep_req_i <= 1'b1;
    @(posedge clk_i);
    sw_sleep_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(5'h08);
    sleep_to(3'h4);
    sw_off_req_i <= 1'b1;
    @(posedge clk_i);
    sw_off_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(5'h14);
  endtask : t_bad_req
  initial
  begin
    t_press();
    t_wakes();
    t_pme_gate();
    t_bad_req();
    close_out();
  end
  // Whole run needs under a thousand cycles; this leaves wide margin.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule : pwr_seq_tb_top

/* File: bench/wake_src_model.sv */
// Power switch and wake sources, all modelled active high.
`timescale 1ns/1ps
module wake_src_model (
  input  wire logic clk_i,
  output logic [6:0] act_o
);
  initial act_o = 7'h00;
  // Lines fall back to idle after each event, so no level lingers.
  task automatic hold(input int i, input int n);
    act_o[i] <= 1'b1;
    repeat (n) @(posedge clk_i);
    act_o[i] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : hold
endmodule : wake_src_model

/* File: rtl/press_timer.sv */
// Synchroniser and press-length classifier for the power switch.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"
module press_timer #(
  parameter logic [27:0] SHORT_CYC = 28'(`SHORT_CYC),
  parameter logic [27:0] LONG_CYC  = 28'(`LONG_CYC)
) (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               switch_i,
  output pwr_seq_pkg::press_t     press_o,
  output logic                    long_hit_o
);
  logic [2:0]       sync_reg;
  logic             level_reg;
  logic [27:0]      cnt_reg;
  logic             fired_reg;
  wire              agree = (sync_reg[1] == sync_reg[2]);
  wire              lvl   = agree ? sync_reg[2] : level_reg;
  wire              sat   = (cnt_reg == 28'hfffffff);
  wire              hit   = level_reg && lvl && !fired_reg && (cnt_reg >= LONG_CYC);
  wire              rel   = level_reg && !lvl;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
      cnt_reg   <= 28'h0;
      fired_reg <= 1'b0;
      press_o   <= pwr_seq_pkg::PR_NONE;
      long_hit_o <= 1'b0;
    end
    else
    begin
      sync_reg   <= {sync_reg[1:0], switch_i};
      level_reg  <= lvl;
      cnt_reg    <= lvl ? (sat ? cnt_reg : cnt_reg + 28'h1) : 28'h0;
      fired_reg  <= lvl ? (fired_reg | hit) : 1'b0;
      long_hit_o <= hit;
      if (rel && !fired_reg)
        press_o <= (cnt_reg < SHORT_CYC) ? pwr_seq_pkg::PR_SHORT : pwr_seq_pkg::PR_MID;
      else
        press_o <= pwr_seq_pkg::PR_NONE;
    end
  end
endmodule : press_timer

/* File: rtl/pwr_seq.sv */
// Global and sleeping power-state controller with wake source gating.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"
module pwr_seq #(
  parameter logic [27:0] SHORT_CYC = 28'(`SHORT_CYC),
  parameter logic [27:0] LONG_CYC  = 28'(`LONG_CYC)
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         switch_i,
  input  wire logic         rtc_wake_i,
  input  wire logic         lan_wake_i,
  input  wire logic         usb_wake_i,
  input  wire logic         pme_n_i,
  input  wire logic         wake_n_i,
  input  wire logic         cir_wake_i,
  input  wire logic         pme_enable_i,
  input  wire logic         sw_sleep_req_i,
  input  wire logic [2:0]   sw_sleep_state_i,
  input  wire logic         sw_off_req_i,
  input  wire logic         last_on_i,
  output logic [1:0]        gstate_o,
  output logic [2:0]        sleep_state_o,
  output logic              main_power_o,
  output logic              cpu_stop_o,
  output logic              wake_event_o
);
  pwr_seq_pkg::gstate_t  st_reg;
  pwr_seq_pkg::gstate_t  st_next;
  logic [2:0]            slp_reg;
  logic [2:0]            slp_next;
  logic                  boot_reg;
  logic [6:0]            sync1_reg;
  logic [6:0]            sync2_reg;
  logic [6:0]            sync3_reg;
  logic [6:0]            src_reg;
  pwr_seq_pkg::press_t   press;
  logic                  long_hit;

  press_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_press (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .switch_i   (switch_i),
    .press_o    (press),
    .long_hit_o (long_hit)
  );

  // Wake sources are pins, so each gets the three-stage agreement filter.
  // Bit map: 1 RTC, 2 LAN, 3 USB, 4 conventional PCI PME, 5 PCI Express wake, 6 IR.
  wire [6:0] raw = {cir_wake_i, !wake_n_i, !pme_n_i, usb_wake_i, lan_wake_i, rtc_wake_i, 1'b0};
  wire [6:0] agree = ~(sync2_reg ^ sync3_reg);
  wire [6:0] src_lvl = (agree & sync3_reg) | (~agree & src_reg);
  wire [6:0] src_rise = src_lvl & ~src_reg;

  function automatic logic is_slp(input logic [2:0] s, input logic [2:0] v);
    is_slp = (s == v);
  endfunction : is_slp

  wire s1 = is_slp(slp_reg, `SLP_S1);
  wire s3 = is_slp(slp_reg, `SLP_S3);
  wire s4 = is_slp(slp_reg, `SLP_S4);
  wire s5 = is_slp(slp_reg, `SLP_S5);
  wire any_slp = s1 | s3 | s4 | s5;
  wire pme_ok = src_rise[4] && pme_enable_i;
  wire usb_ok = src_rise[3] && (s1 | s3);
  wire cir_ok = src_rise[6] && (s3 | s4 | s5);
  wire wake_hit = (any_slp && (src_rise[1] | src_rise[2] | src_rise[5] | pme_ok)) | usb_ok
                  | cir_ok;
  wire sw_slp_ok = is_slp(sw_sleep_state_i, `SLP_S1) | is_slp(sw_sleep_state_i, `SLP_S3)
                   | is_slp(sw_sleep_state_i, `SLP_S4);
  wire short_p = (press == pwr_seq_pkg::PR_SHORT);

  always_comb
  begin
    st_next  = st_reg;
    slp_next = slp_reg;
    case (st_reg)
      pwr_seq_pkg::ST_OFF:
      begin
        if (short_p || wake_hit)
        begin
          st_next  = pwr_seq_pkg::ST_ON;
          slp_next = 3'h0;
        end
      end
      pwr_seq_pkg::ST_ON:
      begin
        if (long_hit || sw_off_req_i)
        begin
          st_next  = pwr_seq_pkg::ST_OFF;
          slp_next = `SLP_S5;
        end
        else if (short_p)
        begin
          st_next  = pwr_seq_pkg::ST_SLEEP;
          slp_next = `SLP_S3;
        end
        else if (sw_sleep_req_i && sw_slp_ok)
        begin
          st_next  = pwr_seq_pkg::ST_SLEEP;
          slp_next = sw_sleep_state_i;
        end
      end
      pwr_seq_pkg::ST_SLEEP:
      begin
        if (long_hit)
        begin
          st_next  = pwr_seq_pkg::ST_OFF;
          slp_next = `SLP_S5;
        end
        else if (short_p || wake_hit)
        begin
          st_next  = pwr_seq_pkg::ST_ON;
          slp_next = 3'h0;
        end
      end
      default:
      begin
        st_next  = pwr_seq_pkg::ST_OFF;
        slp_next = `SLP_S5;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      st_reg       <= pwr_seq_pkg::ST_OFF;
      slp_reg      <= `SLP_S5;
      boot_reg     <= 1'b1;
      sync1_reg    <= 7'h0;
      sync2_reg    <= 7'h0;
      sync3_reg    <= 7'h0;
      src_reg      <= 7'h0;
      wake_event_o <= 1'b0;
    end
    else
    begin
      sync1_reg    <= raw;
      sync2_reg    <= sync1_reg;
      sync3_reg    <= sync2_reg;
      // Edge register starts from zero, so sources high at boot are taken as fresh wakes.
      src_reg      <= boot_reg ? 7'h0 : src_lvl;
      boot_reg     <= 1'b0;
      // In sleep, a long hold in the same cycle wins, so that wake is not reported as taken.
      wake_event_o <= !boot_reg && wake_hit && (st_reg != pwr_seq_pkg::ST_ON)
                      && (st_next == pwr_seq_pkg::ST_ON);
      if (boot_reg)
      begin
        st_reg  <= last_on_i ? pwr_seq_pkg::ST_ON : pwr_seq_pkg::ST_OFF;
        slp_reg <= last_on_i ? 3'h0 : `SLP_S5;
      end
      else
      begin
        st_reg  <= st_next;
        slp_reg <= slp_next;
      end
    end
  end

  assign gstate_o      = st_reg;
  assign sleep_state_o = slp_reg;
  assign main_power_o  = (st_reg == pwr_seq_pkg::ST_ON) || s1;
  assign cpu_stop_o    = s1;
endmodule : pwr_seq

/* File: rtl/pwr_seq_cfg.svh */
// Constants of the power-button and wake sequencer.
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH
`define CLK_HZ        25000000
`define SHORT_SEC     4
`define LONG_SEC      6
`define SHORT_CYC     (`SHORT_SEC * `CLK_HZ)
`define LONG_CYC      (`LONG_SEC * `CLK_HZ)
`define CNT_W         28
`define SLP_S1        3'h1
`define SLP_S3        3'h3
`define SLP_S4        3'h4
`define SLP_S5        3'h5
`endif

/* File: rtl/pwr_seq_pkg.sv */
// Types of the power-button and wake sequencer.
package pwr_seq_pkg;
  typedef enum logic [1:0]
  {
    ST_OFF   = 2'h0,
    ST_ON    = 2'h1,
    ST_SLEEP = 2'h2
  } gstate_t;
  typedef enum logic [1:0]
  {
    PR_NONE  = 2'h0,
    PR_SHORT = 2'h1,
    PR_MID   = 2'h2,
    PR_LONG  = 2'h3
  } press_t;
endpackage : pwr_seq_pkg
